// file: logic/etc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - 44-bit up counter, one step per 244us of enabled time
// - Running count and host copy; update bit gates host copy refresh
// - Power-time mode counts while the configured supply is selected
// - Event mode counts while event gate input is active
// - Configuration picks high or low as active event gate level
// - In event mode, power fail ignores event gate and halts the counter
// - Alarm when 32-bit alarm value equals counter upper 32 bits
// - Selectable periodic interrupt from 244us up to about 24.27 days
// - Interrupt combines alarm and periodic sources, each maskable
// - Alarm and interrupt work on either supply
// - Interrupt pin active low, open drain, only pulls low
// - No valid read data until up to 150 ms recovery elapses
// - Oscillator run bit clear skips recovery, access at once
// - Select and output enable low at power-up still drive pins
// - Oscillator-stopped flag set after detection interval of stoppage
// - Chip select high: pins high impedance, other inputs ignored
// - Select and write enable low write addressed register
// - Read drives pins only while output enable low
// - Power fail forces deselect, no drive, no writes
// - Timebase from 32.768kHz crystal or external oscillator
// - Alarm match sets alarm flag; with enable pulls interrupt low
// - Periodic flag holds until written zero; counter undisturbed
// - Stop detection interval typically 4 ms
module etc_top #(
  parameter longint REC_CYCLES = etc_pkg::REC_CYCLES,
  parameter longint OSF_CYCLES = etc_pkg::OSF_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic [3:0] REG_SEL,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic IRQ_N_OUT,
  output logic IRQ_N_OE,
  input wire logic EVENT_GATE_INPUT,
  input wire logic CRYSTAL_INPUT,
  input wire logic POWER_FAIL,
  input wire logic ON_BACKUP
);
  localparam int CW = etc_pkg::CNT_W;
  localparam int VW = CW + 4;

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  logic [CW-1:0] user_ff;
  logic [etc_pkg::ALM_W-1:0] alarm_ff;
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic alarm_match_flag_ff;
  logic pf_ff;
  logic osf_ff;
  logic match_prev_ff;
  logic rec_busy_ff;
  logic [31:0] rec_cnt_ff;
  logic tick;
  logic stopped;
  logic wr_en;
  logic drive_en;
  logic cnt_en;
  logic step;
  logic match;
  logic pf_hit;
  logic [VW-1:0] view;
  logic [VW-1:0] wr_view;
  logic [VW-1:0] user_view;
  logic [7:0] rd_mux;
  logic [7:0] status;
  logic cnt_wr;
  logic stat_wr;
  logic [3:0] prs;
  logic [5:0] shift;
  logic [CW-1:0] pmask;
  etc_pkg::etc_mode_t mode;

  // Crystal or external oscillator on the same input
  etc_timebase #(
    .DIV(etc_pkg::PRE_DIV),
    .STOP_CYCLES(OSF_CYCLES)
  ) u_timebase (
    .clk(CORE_CLK),
    .rst(RESET),
    .xtal(CRYSTAL_INPUT),
    .run(ctrl_a_ff[etc_pkg::CA_OSCILLATOR_RUN_BIT]),
    .tick(tick),
    .stopped(stopped)
  );

  etc_host_port u_host_port (
    .ce_n(CE_N),
    .oe_n(OE_N),
    .we_n(WE_N),
    .pwr_fail(POWER_FAIL),
    .busy(rec_busy_ff),
    .wr_en(wr_en),
    .drive_en(drive_en)
  );

  assign mode = etc_pkg::etc_mode_t'(ctrl_a_ff[etc_pkg::CA_CCFG +: 2]);

  always_comb begin
    case (mode)
      etc_pkg::ETC_MODE_PRIMARY: cnt_en = ~ON_BACKUP;
      etc_pkg::ETC_MODE_BACKUP: cnt_en = ON_BACKUP;
      etc_pkg::ETC_MODE_EVENT,
      etc_pkg::ETC_MODE_EVENT2: cnt_en = ~POWER_FAIL &
        (EVENT_GATE_INPUT == ctrl_a_ff[etc_pkg::CA_EPOL]);
      default: cnt_en = 1'b0;
    endcase
  end

  assign step = tick & cnt_en;
  assign cnt_wr = wr_en & (REG_SEL <= etc_pkg::ADR_SEC3);
  assign stat_wr = wr_en & (REG_SEL == etc_pkg::ADR_STAT);

  // Count bytes: low nibble of byte 0 is not part of the count
  assign view = {count_ff, 4'h0};
  always_comb begin
    wr_view = view;
    wr_view[REG_SEL[2:0]*8 +: 8] = DATA_IN;
    nxt_count = count_ff;
    if (cnt_wr) begin
      nxt_count = wr_view[VW-1:4];
    end else if (step) begin
      nxt_count = count_ff + 44'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Frozen host copy lets software read all bytes consistently
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      user_ff <= '0;
    end else if (cnt_wr || (step && ctrl_a_ff[etc_pkg::CA_TE])) begin
      user_ff <= nxt_count;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      alarm_ff <= '0;
      ctrl_a_ff <= etc_pkg::CTLA_RST;
      ctrl_b_ff <= etc_pkg::CTLB_RST;
    end else if (wr_en) begin
      if (REG_SEL >= etc_pkg::ADR_ALM0 && REG_SEL <= etc_pkg::ADR_ALM3) begin
        alarm_ff[(REG_SEL - etc_pkg::ADR_ALM0)*8 +: 8] <= DATA_IN;
      end
      if (REG_SEL == etc_pkg::ADR_CTLA) begin
        ctrl_a_ff <= DATA_IN;
      end
      if (REG_SEL == etc_pkg::ADR_CTLB) begin
        ctrl_b_ff <= DATA_IN;
      end
    end
  end

  // Edge of match so a cleared flag is not set again at once
  assign match = count_ff[CW-1:etc_pkg::SUB_W] == alarm_ff;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      match_prev_ff <= 1'b0;
    end else begin
      match_prev_ff <= match;
    end
  end

  assign prs = ctrl_b_ff[etc_pkg::CB_PRS +: 4];
  assign shift = (prs == 4'h0) ? 6'h00 : etc_pkg::PRS_SHIFT[prs - 4'h1];
  assign pmask = (44'h1 << shift) - 44'h1;
  // Count writes also move the periodic point
  assign pf_hit = (prs != 4'h0) && (cnt_wr || step) &&
    ((nxt_count & pmask) == '0);

  // Hardware set beats a host clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      alarm_match_flag_ff <= 1'b0;
      pf_ff <= 1'b0;
      osf_ff <= 1'b0;
    end else begin
      if (match && !match_prev_ff) begin
        alarm_match_flag_ff <= 1'b1;
      end else if (stat_wr && !DATA_IN[etc_pkg::ST_ALARM_MATCH_FLAG]) begin
        alarm_match_flag_ff <= 1'b0;
      end
      if (pf_hit) begin
        pf_ff <= 1'b1;
      end else if (stat_wr && !DATA_IN[etc_pkg::ST_PF]) begin
        pf_ff <= 1'b0;
      end
      if (stopped) begin
        osf_ff <= 1'b1;
      end else if (stat_wr && !DATA_IN[etc_pkg::ST_OSF]) begin
        osf_ff <= 1'b0;
      end
    end
  end

  // Recovery only when the oscillator is enabled
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rec_busy_ff <= 1'b1;
      rec_cnt_ff <= '0;
    end else if (!ctrl_a_ff[etc_pkg::CA_OSCILLATOR_RUN_BIT]) begin
      rec_busy_ff <= 1'b0;
    end else if (rec_busy_ff) begin
      rec_cnt_ff <= rec_cnt_ff + 32'h1;
      if (rec_cnt_ff >= 32'(REC_CYCLES - 1)) begin
        rec_busy_ff <= 1'b0;
      end
    end
  end

  assign status = {osf_ff, 5'h00, pf_ff, alarm_match_flag_ff};
  // Host copy laid out like the count bytes
  assign user_view = {user_ff, 4'h0};
  always_comb begin
    rd_mux = 8'h00;
    if (REG_SEL <= etc_pkg::ADR_SEC3) begin
      rd_mux = user_view[REG_SEL[2:0]*8 +: 8];
    end else if (REG_SEL <= etc_pkg::ADR_ALM3) begin
      rd_mux = alarm_ff[(REG_SEL - etc_pkg::ADR_ALM0)*8 +: 8];
    end else if (REG_SEL == etc_pkg::ADR_CTLA) begin
      rd_mux = ctrl_a_ff;
    end else if (REG_SEL == etc_pkg::ADR_CTLB) begin
      rd_mux = ctrl_b_ff;
    end else if (REG_SEL == etc_pkg::ADR_STAT) begin
      rd_mux = status;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      DATA_OUT <= 8'h00;
    end else begin
      DATA_OUT <= rec_busy_ff ? 8'h00 : rd_mux;
    end
  end

  assign DATA_OE = drive_en;
  // Only ever pulls low; pull-up makes the high level
  assign IRQ_N_OUT = 1'b0;
  assign IRQ_N_OE = (alarm_match_flag_ff & ctrl_a_ff[etc_pkg::CA_AIE]) |
    (pf_ff & ctrl_a_ff[etc_pkg::CA_PIE]);

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  sequence bus_write_s;
    !CE_N && !WE_N && !POWER_FAIL && !rec_busy_ff;
  endsequence
  sequence ctla_write_s;
    bus_write_s ##0 (REG_SEL == etc_pkg::ADR_CTLA);
  endsequence

  deselect_hiz_a: assert property (CE_N |-> !DATA_OE)
    else $error("data pins driven while deselected");
  pfail_deselect_a: assert property (POWER_FAIL |=>
    ctrl_a_ff == $past(ctrl_a_ff) && !$past(DATA_OE))
    else $error("register changed or pins driven in power fail");
  read_drive_a: assert property ((!CE_N && WE_N && !POWER_FAIL) |->
    DATA_OE == !OE_N)
    else $error("read drive does not follow output enable");
  ctla_write_a: assert property (ctla_write_s |=>
    ctrl_a_ff == $past(DATA_IN))
    else $error("control write not captured");
  irq_open_drain_a: assert property (IRQ_N_OUT == 1'b0 &&
    IRQ_N_OE == ((alarm_match_flag_ff && ctrl_a_ff[0]) || (pf_ff && ctrl_a_ff[1])))
    else $error("interrupt pin not open drain or wrong sources");
  count_step_a: assert property ((step && !cnt_wr) |=>
    count_ff == $past(count_ff) + 44'h1)
    else $error("counter did not advance by one");
  count_hold_a: assert property ((!step && !cnt_wr) |=> $stable(count_ff))
    else $error("counter moved without enable");
  event_pfail_a: assert property ((ctrl_a_ff[5] && POWER_FAIL) |-> !cnt_en)
    else $error("event mode counting in power fail");
  user_hold_a: assert property ((!ctrl_a_ff[7] && !cnt_wr) |=>
    $stable(user_ff))
    else $error("host copy refreshed while update disabled");
  alarm_flag_a: assert property ((match && !match_prev_ff) |=>
    alarm_match_flag_ff ##1 (alarm_match_flag_ff || $past(stat_wr)))
    else $error("alarm match did not set flag");
  pf_hold_a: assert property ((pf_ff && !stat_wr) |=> pf_ff)
    else $error("periodic flag dropped without host clear");
  rec_read_a: assert property (rec_busy_ff |=> DATA_OUT == 8'h00)
    else $error("read data presented during recovery");
  rec_skip_a: assert property (!ctrl_a_ff[6] |=> !rec_busy_ff)
    else $error("recovery not skipped with oscillator off");
  osf_set_a: assert property (stopped |=> osf_ff)
    else $error("stop flag not set");

  sequence sub_write_s;
    bus_write_s ##0 (REG_SEL == etc_pkg::ADR_SUB0);
  endsequence
  sequence alm_write_s;
    bus_write_s ##0 (REG_SEL == etc_pkg::ADR_ALM0);
  endsequence

  primary_time_a: assert property ((ctrl_a_ff[5:4] == 2'b00) |->
    cnt_en == !ON_BACKUP)
    else $error("primary time enable does not follow supply switch");
  backup_time_a: assert property ((ctrl_a_ff[5:4] == 2'b01) |->
    cnt_en == ON_BACKUP)
    else $error("backup time enable does not follow supply switch");
  event_gate_a: assert property ((ctrl_a_ff[5] && !POWER_FAIL) |->
    cnt_en == (EVENT_GATE_INPUT == ctrl_a_ff[3]))
    else $error("event enable does not follow gate level");
  osc_tick_a: assert property (!$past(ctrl_a_ff[6]) |-> !tick)
    else $error("count step with oscillator disabled");
  pf_set_a: assert property (pf_hit |=> pf_ff)
    else $error("periodic point did not set flag");
  pf_off_a: assert property ((prs == 4'h0 && !pf_ff) |=> !pf_ff)
    else $error("periodic flag set while periodic rate is off");
  pf_clear_a: assert property ((stat_wr && !DATA_IN[1] && !pf_hit) |=>
    !pf_ff)
    else $error("periodic flag not cleared by host write");
  rec_drive_a: assert property ((rec_busy_ff && !CE_N && !OE_N &&
    WE_N && !POWER_FAIL) |-> DATA_OE)
    else $error("pins not driven for read during recovery");
  osf_hold_a: assert property ((osf_ff && !stat_wr) |=> osf_ff)
    else $error("stop flag dropped without host clear");
  user_copy_a: assert property ((step && ctrl_a_ff[7]) |=>
    user_ff == count_ff)
    else $error("host copy not refreshed on count step");
  sub_write_a: assert property (sub_write_s |=>
    count_ff[3:0] == $past(DATA_IN[7:4]))
    else $error("count byte write not captured");
  alarm_write_a: assert property (alm_write_s |=>
    alarm_ff[7:0] == $past(DATA_IN))
    else $error("alarm byte write not captured");
  alarm_pfail_a: assert property (POWER_FAIL |=> $stable(alarm_ff))
    else $error("alarm register changed in power fail");
  alarm_irq_a: assert property ((alarm_match_flag_ff && ctrl_a_ff[0]) |-> IRQ_N_OE)
    else $error("enabled alarm flag does not pull interrupt");
  rec_once_a: assert property (!rec_busy_ff |=> !rec_busy_ff)
    else $error("recovery restarted without reset");
endmodule

// file: logic/etc_pkg.sv
package etc_pkg;
  localparam int CNT_W = 44;
  localparam int ALM_W = 32;
  localparam int SUB_W = 12;
  localparam int PRE_DIV = 8;
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam longint REC_TIME_MS = 150;
  localparam longint REC_CYCLES = REC_TIME_MS * CLK_FREQ_HZ / 1000;
  localparam longint OSF_TIME_MS = 4;
  localparam longint OSF_CYCLES = OSF_TIME_MS * CLK_FREQ_HZ / 1000;
  localparam logic [3:0] ADR_SUB0 = 4'h0;
  localparam logic [3:0] ADR_SEC3 = 4'h5;
  localparam logic [3:0] ADR_ALM0 = 4'h6;
  localparam logic [3:0] ADR_ALM3 = 4'h9;
  localparam logic [3:0] ADR_CTLA = 4'hA;
  localparam logic [3:0] ADR_CTLB = 4'hB;
  localparam logic [3:0] ADR_STAT = 4'hC;
  localparam int CA_TE = 7;
  localparam int CA_OSCILLATOR_RUN_BIT = 6;
  localparam int CA_CCFG = 4;
  localparam int CA_EPOL = 3;
  localparam int CA_PIE = 1;
  localparam int CA_AIE = 0;
  localparam int CB_PRS = 4;
  localparam int ST_OSF = 7;
  localparam int ST_PF = 1;
  localparam int ST_ALARM_MATCH_FLAG = 0;
  localparam logic [7:0] CTLA_RST = 8'h40;
  localparam logic [7:0] CTLB_RST = 8'h00;
  typedef enum logic [1:0] {
    ETC_MODE_PRIMARY = 2'b00,
    ETC_MODE_BACKUP = 2'b01,
    ETC_MODE_EVENT = 2'b10,
    ETC_MODE_EVENT2 = 2'b11
  } etc_mode_t;
  typedef logic [5:0] etc_shift_t;
  localparam etc_shift_t PRS_SHIFT [15] = '{
    6'h00, 6'h03, 6'h06, 6'h09, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
    6'h11, 6'h13, 6'h15, 6'h18, 6'h1B, 6'h1E, 6'h21
  };
endpackage

// file: logic/etc_timebase.sv
`timescale 1ns/1ps
module etc_timebase #(
  parameter int DIV = 8,
  parameter longint STOP_CYCLES = 160000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic xtal,
  input wire logic run,
  output logic tick,
  output logic stopped
);
  localparam int PW = $clog2(DIV);
  logic xtal_d_ff;
  logic [PW-1:0] pre_ff;
  logic [31:0] idle_ff;
  logic rise;

  assign rise = xtal & ~xtal_d_ff & run;

  always_ff @(posedge clk) begin
    if (rst) begin
      xtal_d_ff <= 1'b0;
    end else begin
      xtal_d_ff <= xtal;
    end
  end

  // One count step per DIV source edges
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_ff <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (rise) begin
        pre_ff <= pre_ff + 1'b1;
        if (pre_ff == PW'(DIV - 1)) begin
          tick <= 1'b1;
          pre_ff <= '0;
        end
      end
    end
  end

  // Counter saturates so a dead source keeps the flag up
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_ff <= '0;
      stopped <= 1'b0;
    end else if (rise) begin
      idle_ff <= '0;
      stopped <= 1'b0;
    end else if (idle_ff >= 32'(STOP_CYCLES - 1)) begin
      stopped <= 1'b1;
    end else begin
      idle_ff <= idle_ff + 32'h1;
    end
  end
endmodule

// file: logic/etc_host_port.sv
`timescale 1ns/1ps
module etc_host_port (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic pwr_fail,
  input wire logic busy,
  output logic wr_en,
  output logic drive_en
);
  logic sel;

  // Power fail overrides every bus pin
  assign sel = ~ce_n & ~pwr_fail;
  // Write is independent of output enable
  assign wr_en = sel & ~we_n & ~busy;
  // Pins still drive during recovery; data there is meaningless
  assign drive_en = sel & we_n & ~oe_n;
endmodule

// file: dv/etc_host_model.sv
`timescale 1ns/1ps
module etc_host_model (
  input wire logic CLK,
  output logic CE_N,
  output logic OE_N,
  output logic WE_N,
  output logic [3:0] REG_SEL,
  output logic [7:0] DATA_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE
);
  initial begin
    CE_N = 1'b1;
    OE_N = 1'b1;
    WE_N = 1'b1;
    REG_SEL = 4'h0;
    DATA_IN = 8'hA5;
  end
  // One write per edge, so the strobe stays low for exactly one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge CLK);
    CE_N = 1'b0;
    WE_N = 1'b0;
    REG_SEL = a;
    DATA_IN = d;
    @(negedge CLK);
    CE_N = 1'b1;
    WE_N = 1'b1;
    // Released bus shows the inverse, never a stale match
    DATA_IN = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d,
    output logic oe);
    @(negedge CLK);
    CE_N = 1'b0;
    OE_N = 1'b0;
    REG_SEL = a;
    @(negedge CLK);
    @(negedge CLK);
    d = DATA_OUT;
    oe = DATA_OE;
    CE_N = 1'b1;
    OE_N = 1'b1;
  endtask
  task automatic pins(input logic ce, input logic oe, input logic we);
    @(negedge CLK);
    CE_N = ce;
    OE_N = oe;
    WE_N = we;
  endtask
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce_n, oe_n, we_n, doe, irq_out, irq_oe, oeo;
  logic [3:0] sel;
  logic [7:0] din, dout, v, r;
  logic gate = 1'b0;
  logic xtal = 1'b0;
  logic xrun = 1'b1;
  logic pfail = 1'b0;
  logic bkup = 1'b1;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  // Fast crystal keeps the run short: one count every 64 core cycles
  always #100 xtal = xrun ? ~xtal : xtal;
  etc_top #(.REC_CYCLES(20), .OSF_CYCLES(50)) uut (
    .CORE_CLK(clk), .RESET(rst), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
    .REG_SEL(sel), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
    .IRQ_N_OUT(irq_out), .IRQ_N_OE(irq_oe), .EVENT_GATE_INPUT(gate),
    .CRYSTAL_INPUT(xtal), .POWER_FAIL(pfail), .ON_BACKUP(bkup));
  etc_host_model host (.CLK(clk), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
    .REG_SEL(sel), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe));
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk8(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e,
    input string nm);
    host.rd(a, r, oeo);
    chk8(nm, e, r);
    chk1("rd_drive", 1'b1, oeo);
  endtask
  // Bounded wait, so a dead interrupt cannot hang the run
  task automatic wait_irq(input string nm, input logic e);
    for (int i = 0; i < 200 && irq_oe !== e; i++)
      @(negedge clk);
    chk1(nm, e, irq_oe);
  endtask
  task automatic t_recovery();
    rdc(etc_pkg::ADR_CTLA, 8'h00, "ctla_recov");
    host.wr(etc_pkg::ADR_CTLB, 8'h55);
    idle(30);
    rdc(etc_pkg::ADR_CTLA, etc_pkg::CTLA_RST, "ctla_rst");
    rdc(etc_pkg::ADR_CTLB, etc_pkg::CTLB_RST, "ctlb_rst");
    chk1("irq_level", 1'b0, irq_out);
    $display("Test recovery done");
  endtask
  task automatic t_pins();
    host.pins(1'b1, 1'b0, 1'b1);
    #1;
    chk1("oe_desel", 1'b0, doe);
    host.pins(1'b0, 1'b0, 1'b1);
    #1;
    chk1("oe_read", 1'b1, doe);
    host.pins(1'b0, 1'b1, 1'b1);
    #1;
    chk1("oe_off", 1'b0, doe);
    host.pins(1'b0, 1'b0, 1'b1);
    pfail = 1'b1;
    #1;
    chk1("oe_pfail", 1'b0, doe);
    host.pins(1'b1, 1'b1, 1'b1);
    host.wr(etc_pkg::ADR_CTLB, 8'hFF);
    pfail = 1'b0;
    rdc(etc_pkg::ADR_CTLB, 8'h00, "ctlb_pfail");
    $display("Test pins done");
  endtask
  task automatic t_alarm();
    host.wr(etc_pkg::ADR_CTLA, 8'hC0);
    host.wr(etc_pkg::ADR_SUB0, 8'hF0);
    host.wr(4'h1, 8'hFF);
    for (int i = 2; i < 6; i++)
      host.wr(4'(i), 8'h00);
    host.wr(etc_pkg::ADR_ALM0, 8'h01);
    for (int i = 7; i < 10; i++)
      host.wr(4'(i), 8'h00);
    host.wr(etc_pkg::ADR_STAT, 8'h00);
    host.wr(etc_pkg::ADR_CTLA, 8'hC1);
    idle(200);
    chk1("irq_halted", 1'b0, irq_oe);
    bkup = 1'b0;
    wait_irq("irq_alarm", 1'b1);
    rdc(etc_pkg::ADR_STAT, 8'h01, "stat_alm");
    host.wr(etc_pkg::ADR_STAT, 8'h00);
    idle(1);
    chk1("irq_alm_clr", 1'b0, irq_oe);
    $display("Test alarm done");
  endtask
  task automatic t_periodic();
    host.wr(etc_pkg::ADR_CTLA, 8'hC2);
    host.wr(etc_pkg::ADR_CTLB, 8'h10);
    wait_irq("irq_pf", 1'b1);
    // Rate off first, so no new set can race the clear below
    host.wr(etc_pkg::ADR_CTLB, 8'h00);
    idle(100);
    rdc(etc_pkg::ADR_STAT, 8'h02, "stat_pf");
    host.wr(etc_pkg::ADR_STAT, 8'h00);
    idle(1);
    chk1("irq_pf_clr", 1'b0, irq_oe);
    host.wr(etc_pkg::ADR_STAT, 8'h00);
    bkup = 1'b1;
    $display("Test periodic done");
  endtask
  task automatic t_event(input logic pol);
    gate = ~pol;
    host.wr(etc_pkg::ADR_CTLA, {4'b1110, pol, 3'b000});
    host.wr(etc_pkg::ADR_SUB0, 8'h00);
    idle(200);
    rdc(etc_pkg::ADR_SUB0, 8'h00, "ev_idle");
    gate = pol;
    idle(200);
    gate = ~pol;
    host.rd(etc_pkg::ADR_SUB0, v, oeo);
    chk1("ev_run", 1'b1, v != 8'h00);
    gate = pol;
    pfail = 1'b1;
    idle(200);
    gate = ~pol;
    pfail = 1'b0;
    rdc(etc_pkg::ADR_SUB0, v, "ev_pfail");
    $display("Test event polarity %b done", pol);
  endtask
  task automatic t_backup();
    bkup = 1'b0;
    host.wr(etc_pkg::ADR_CTLA, 8'hD0);
    host.wr(etc_pkg::ADR_SUB0, 8'h00);
    idle(200);
    rdc(etc_pkg::ADR_SUB0, 8'h00, "bk_idle");
    bkup = 1'b1;
    idle(200);
    bkup = 1'b0;
    host.rd(etc_pkg::ADR_SUB0, v, oeo);
    chk1("bk_run", 1'b1, v != 8'h00);
    $display("Test backup time done");
  endtask
  task automatic t_osf();
    xrun = 1'b0;
    idle(80);
    rdc(etc_pkg::ADR_STAT, 8'h80, "stat_osf");
    xrun = 1'b1;
    $display("Test oscillator stop done");
  endtask
  initial begin
    idle(2);
    rst = 1'b0;
    t_recovery();
    t_pins();
    t_alarm();
    t_periodic();
    t_event(1'b1);
    t_event(1'b0);
    t_backup();
    t_osf();
    report_and_stop();
  end
endmodule
